// *** logic/ctad_regs.svh ***
// What this block does
// - Transfer moves B, W or L data reg to reg, mem to reg, reg to mem or imm.
// - Stack pull loads a word or long at the stack pointer, then steps it up.
// - Stack store steps the stack pointer down, then writes a word or long.
// - Sum and difference add or subtract a register or immediate, any size.
// - Difference refuses a byte immediate.
// - Sum with carry and difference with borrow are byte only, using carry.
// - Step up and step down add or subtract 1 or 2 at any size.
// - Byte steps allow a step of 1 only.
// - Pointer steps add or subtract 1, 2 or 4 on a 32-bit register, long only.
// - The BCD fixes turn a byte sum or difference into BCD digits by flags.
// - Unsigned multiply gives 8x8 to 16 bits or 16x16 to 32 bits.
// - Signed multiply does the same on two's complement operands.
// - Eight 32-bit registers, each two 16-bit halves, the low half two bytes.
// - Flags N, Z, V, C are set by arithmetic, read by carry and BCD ops.
// - Immediate and displacement fields are 3, 8, 16 or 24 bits long.
`ifndef CTAD_REGS_SVH
`define CTAD_REGS_SVH

`define CTAD_SP_IDX    3'h7
`define CTAD_GPR_RST   32'h0000_0000
`define CTAD_FLAG_RST  1'b0
`define CTAD_LEN_3     2'h0
`define CTAD_LEN_8     2'h1
`define CTAD_LEN_16    2'h2
`define CTAD_LEN_24    2'h3
`define CTAD_STEP_1    32'h0000_0001
`define CTAD_STEP_2    32'h0000_0002
`define CTAD_STEP_4    32'h0000_0004
`define CTAD_BCD_LO    8'h06
`define CTAD_BCD_HI    8'h60

`endif

// *** logic/ctad_pkg.sv ***
package ctad_pkg;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } ctad_size_t;

    typedef enum logic [4:0] {
        OP_XFER_RR     = 5'h00,
        OP_XFER_IMM    = 5'h01,
        OP_XFER_LOAD   = 5'h02,
        OP_XFER_STORE  = 5'h03,
        OP_STACK_PULL  = 5'h04,
        OP_STACK_STORE = 5'h05,
        OP_SUM         = 5'h06,
        OP_DIFF        = 5'h07,
        OP_SUM_CARRY   = 5'h08,
        OP_DIFF_BORROW = 5'h09,
        OP_STEP_UP     = 5'h0A,
        OP_STEP_DOWN   = 5'h0B,
        OP_PTR_UP      = 5'h0C,
        OP_PTR_DOWN    = 5'h0D,
        OP_BCD_SUM     = 5'h0E,
        OP_BCD_DIFF    = 5'h0F,
        OP_MUL_U       = 5'h10,
        OP_MUL_S       = 5'h11,
        OP_PSYNC_RD    = 5'h12,
        OP_PSYNC_WR    = 5'h13
    } ctad_op_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_MEM  = 1'b1
    } ctad_state_t;

endpackage

// *** logic/ctad_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ctad_regs.svh"

module ctad_alu (
    input  wire ctad_pkg::ctad_op_t   op,
    input  wire ctad_pkg::ctad_size_t size,
    input  wire logic [31:0]          a,
    input  wire logic [31:0]          b,
    input  wire logic                 c_in,
    input  wire logic                 h_in,
    input  wire logic                 z_in,
    output logic [31:0]               res,
    output logic                      n_out,
    output logic                      z_out,
    output logic                      v_out,
    output logic                      c_out,
    output logic                      h_out,
    output logic                      upd_nz,
    output logic                      upd_v,
    output logic                      upd_c
);
    logic [31:0] bb;
    logic [31:0] cx;
    logic [32:0] s33;
    logic [31:0] zmask;
    logic [4:0]  msb;
    logic        cin;
    logic        sub;
    logic        cy;
    logic [7:0]  corr;
    logic [15:0] p16;
    logic [31:0] p32;
    logic        dadd;

    always_comb begin
        sub = 1'b0;
        cin = 1'b0;
        bb  = b;
        dadd = (op == ctad_pkg::OP_BCD_SUM);
        unique case (op)
            ctad_pkg::OP_DIFF, ctad_pkg::OP_STEP_DOWN: begin
                sub = 1'b1;
                cin = 1'b1;
                bb  = ~b;
            end
            ctad_pkg::OP_SUM_CARRY: cin = c_in;
            ctad_pkg::OP_DIFF_BORROW: begin
                sub = 1'b1;
                cin = ~c_in;
                bb  = ~b;
            end
            default: ;
        endcase
        s33 = {1'b0, a} + {1'b0, bb} + {32'h0000_0000, cin};
        cx  = a ^ bb ^ s33[31:0];
        unique case (size)
            ctad_pkg::SZ_BYTE: begin
                msb   = 5'h07;
                cy    = cx[8];
                h_out = cx[4];
                zmask = 32'h0000_00FF;
            end
            ctad_pkg::SZ_WORD: begin
                msb   = 5'h0F;
                cy    = cx[16];
                h_out = cx[12];
                zmask = 32'h0000_FFFF;
            end
            default: begin
                msb   = 5'h1F;
                cy    = s33[32];
                h_out = cx[28];
                zmask = 32'hFFFF_FFFF;
            end
        endcase
        res    = s33[31:0];
        v_out  = cx[msb] ^ cy;
        c_out  = cy ^ sub;
        upd_nz = 1'b1;
        upd_v  = 1'b1;
        upd_c  = 1'b1;
        corr   = 8'h00;
        p16    = 16'h0000;
        p32    = 32'h0000_0000;
        unique case (op)
            ctad_pkg::OP_XFER_RR, ctad_pkg::OP_XFER_IMM,
            ctad_pkg::OP_XFER_LOAD, ctad_pkg::OP_XFER_STORE,
            ctad_pkg::OP_STACK_PULL, ctad_pkg::OP_STACK_STORE: begin
                res   = b;
                v_out = 1'b0;
                upd_c = 1'b0;
            end
            ctad_pkg::OP_STEP_UP, ctad_pkg::OP_STEP_DOWN: upd_c = 1'b0;
            ctad_pkg::OP_PTR_UP, ctad_pkg::OP_PTR_DOWN: begin
                res    = (op == ctad_pkg::OP_PTR_UP) ? a + b : a - b;
                upd_nz = 1'b0;
                upd_v  = 1'b0;
                upd_c  = 1'b0;
            end
            ctad_pkg::OP_BCD_SUM, ctad_pkg::OP_BCD_DIFF: begin
                if (h_in || (dadd && a[3:0] > 4'h9)) begin
                    corr = corr | `CTAD_BCD_LO;
                end
                c_out = c_in;
                if (c_in || (dadd && a[7:0] > 8'h99)) begin
                    corr  = corr | `CTAD_BCD_HI;
                    c_out = 1'b1;
                end
                res   = {24'h00_0000, dadd ? a[7:0] + corr : a[7:0] - corr};
                upd_v = 1'b0;
            end
            ctad_pkg::OP_MUL_U, ctad_pkg::OP_MUL_S: begin
                if (op == ctad_pkg::OP_MUL_S) begin
                    p16 = 16'($signed(a[7:0])) * 16'($signed(b[7:0]));
                    p32 = 32'($signed(a[15:0])) * 32'($signed(b[15:0]));
                end else begin
                    p16 = 16'(a[7:0]) * 16'(b[7:0]);
                    p32 = 32'(a[15:0]) * 32'(b[15:0]);
                end
                if (size == ctad_pkg::SZ_BYTE) begin
                    res   = {16'h0000, p16};
                    msb   = 5'h0F;
                    zmask = 32'h0000_FFFF;
                end else begin
                    res   = p32;
                    msb   = 5'h1F;
                    zmask = 32'hFFFF_FFFF;
                end
                upd_nz = (op == ctad_pkg::OP_MUL_S);
                upd_v  = 1'b0;
                upd_c  = 1'b0;
            end
            default: ;
        endcase
        n_out = res[msb];
        z_out = ((res & zmask) == 32'h0000_0000);
        if (op == ctad_pkg::OP_SUM_CARRY ||
            op == ctad_pkg::OP_DIFF_BORROW) begin
            z_out = z_out & z_in;
        end
    end

endmodule // ctad_alu
`default_nettype wire

// *** logic/ctad_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ctad_regs.svh"

module ctad_datapath (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 op_valid,
    input  wire ctad_pkg::ctad_op_t   op_code,
    input  wire ctad_pkg::ctad_size_t op_size,
    input  wire logic [3:0]           dst_sel,
    input  wire logic [3:0]           src_sel,
    input  wire logic                 src_is_imm,
    input  wire logic [23:0]          field_raw,
    input  wire logic [1:0]           field_len,
    input  wire logic [31:0]          mem_rdata,
    input  wire logic                 mem_ack,
    output logic                      op_done,
    output logic                      op_illegal,
    output logic                      op_busy,
    output logic                      mem_req,
    output logic                      mem_we,
    output logic [31:0]               mem_addr,
    output logic [31:0]               mem_wdata,
    output ctad_pkg::ctad_size_t      mem_size,
    output logic [31:0]               result_data,
    output logic                      flag_n,
    output logic                      flag_z,
    output logic                      flag_v,
    output logic                      flag_c
);
    ctad_pkg::ctad_state_t state, next_state;
    logic [31:0]           gpr [8], next_gpr [8];
    logic                  flag_h;
    logic                  next_flag_n, next_flag_z, next_flag_v;
    logic                  next_flag_c, next_flag_h;
    logic                  next_op_done, next_op_illegal;
    logic                  next_mem_req, next_mem_we;
    logic [31:0]           next_mem_addr, next_mem_wdata, next_result_data;
    ctad_pkg::ctad_size_t  next_mem_size;
    logic [3:0]            pend_dst, next_pend_dst;
    logic                  pend_pull, next_pend_pull;
    ctad_pkg::ctad_op_t    alu_op;
    ctad_pkg::ctad_size_t  alu_size, wr_size;
    logic [31:0]           alu_a, alu_b, alu_res, imm_val, disp_val;
    logic [31:0]           sp_val, sp_step;
    logic                  is_mul, bad;
    logic                  a_n, a_z, a_v, a_c, a_h, u_nz, u_v, u_c;

    // Field of 3, 8, 16 or 24 bits, zero or sign extended
    function automatic logic [31:0] decode_field(input logic [23:0] raw,
                                                 input logic [1:0]  len,
                                                 input logic        sgn);
        logic [31:0] v;
        v = {8'h00, raw};
        unique case (len)
            `CTAD_LEN_3:  v = {29'h0000_0000, raw[2:0]};
            `CTAD_LEN_8:  v = {{24{sgn & raw[7]}}, raw[7:0]};
            `CTAD_LEN_16: v = {{16{sgn & raw[15]}}, raw[15:0]};
            `CTAD_LEN_24: v = {{8{sgn & raw[23]}}, raw};
        endcase
        return v;
    endfunction

    // Byte: alt=0 high byte, alt=1 low byte; word: alt=1 upper half
    function automatic logic [31:0] view_rd(input logic [31:0]          r,
                                            input ctad_pkg::ctad_size_t sz,
                                            input logic                 alt);
        logic [31:0] v;
        v = r;
        if (sz == ctad_pkg::SZ_BYTE) begin
            v = {24'h00_0000, alt ? r[7:0] : r[15:8]};
        end else if (sz == ctad_pkg::SZ_WORD) begin
            v = {16'h0000, alt ? r[31:16] : r[15:0]};
        end
        return v;
    endfunction

    function automatic logic [31:0] view_wr(input logic [31:0]          r,
                                            input logic [31:0]          d,
                                            input ctad_pkg::ctad_size_t sz,
                                            input logic                 alt);
        logic [31:0] v;
        v = d;
        if (sz == ctad_pkg::SZ_BYTE) begin
            v = alt ? {r[31:8], d[7:0]} : {r[31:16], d[7:0], r[7:0]};
        end else if (sz == ctad_pkg::SZ_WORD) begin
            v = alt ? {d[15:0], r[15:0]} : {r[31:16], d[15:0]};
        end
        return v;
    endfunction

    ctad_alu u_alu (
        .op     (alu_op),
        .size   (alu_size),
        .a      (alu_a),
        .b      (alu_b),
        .c_in   (flag_c),
        .h_in   (flag_h),
        .z_in   (flag_z),
        .res    (alu_res),
        .n_out  (a_n),
        .z_out  (a_z),
        .v_out  (a_v),
        .c_out  (a_c),
        .h_out  (a_h),
        .upd_nz (u_nz),
        .upd_v  (u_v),
        .upd_c  (u_c)
    );

    always_comb begin
        imm_val  = decode_field(field_raw, field_len, 1'b0);
        disp_val = decode_field(field_raw, field_len, 1'b1);
        sp_val   = gpr[`CTAD_SP_IDX];
        sp_step  = (op_size == ctad_pkg::SZ_LONG) ? `CTAD_STEP_4
                                                   : `CTAD_STEP_2;
        is_mul   = op_code inside {ctad_pkg::OP_MUL_U, ctad_pkg::OP_MUL_S};
        wr_size  = op_size;
        if (is_mul) begin
            wr_size = (op_size == ctad_pkg::SZ_BYTE) ? ctad_pkg::SZ_WORD
                                                    : ctad_pkg::SZ_LONG;
        end
        bad = (op_size == ctad_pkg::SZ_LONG) && is_mul;
        unique case (op_code)
            ctad_pkg::OP_DIFF:
                bad = src_is_imm && (op_size == ctad_pkg::SZ_BYTE);
            ctad_pkg::OP_SUM_CARRY, ctad_pkg::OP_DIFF_BORROW,
            ctad_pkg::OP_BCD_SUM, ctad_pkg::OP_BCD_DIFF:
                bad = (op_size != ctad_pkg::SZ_BYTE);
            ctad_pkg::OP_STEP_UP, ctad_pkg::OP_STEP_DOWN:
                bad = !(imm_val == `CTAD_STEP_1 ||
                        (imm_val == `CTAD_STEP_2 &&
                         op_size != ctad_pkg::SZ_BYTE));
            ctad_pkg::OP_PTR_UP, ctad_pkg::OP_PTR_DOWN:
                bad = (op_size != ctad_pkg::SZ_LONG) ||
                      !(imm_val == `CTAD_STEP_1 || imm_val == `CTAD_STEP_2 ||
                        imm_val == `CTAD_STEP_4);
            ctad_pkg::OP_STACK_PULL, ctad_pkg::OP_STACK_STORE:
                bad = (op_size == ctad_pkg::SZ_BYTE);
            ctad_pkg::OP_PSYNC_RD, ctad_pkg::OP_PSYNC_WR:
                bad = 1'b1;
            default: ;
        endcase
        alu_op   = op_code;
        alu_size = op_size;
        alu_a    = view_rd(gpr[dst_sel[2:0]], wr_size, dst_sel[3]);
        alu_b    = src_is_imm ? imm_val
                              : view_rd(gpr[src_sel[2:0]], op_size,
                                        src_sel[3]);
        if (op_code inside {ctad_pkg::OP_STEP_UP, ctad_pkg::OP_STEP_DOWN,
                            ctad_pkg::OP_PTR_UP, ctad_pkg::OP_PTR_DOWN}) begin
            alu_b = imm_val;
        end
        if (op_code == ctad_pkg::OP_STACK_STORE) begin
            alu_b = view_rd(gpr[dst_sel[2:0]], op_size, dst_sel[3]);
        end
        if (state == ctad_pkg::ST_MEM) begin
            alu_op   = ctad_pkg::OP_XFER_LOAD;
            alu_size = mem_size;
            alu_b    = mem_rdata;
        end
    end

    always_comb begin
        next_state       = state;
        next_gpr         = gpr;
        {next_flag_n, next_flag_z, next_flag_v, next_flag_c, next_flag_h} =
            {flag_n, flag_z, flag_v, flag_c, flag_h};
        next_op_done     = 1'b0;
        next_op_illegal  = 1'b0;
        next_mem_req     = mem_req;
        next_mem_we      = mem_we;
        next_mem_addr    = mem_addr;
        next_mem_wdata   = mem_wdata;
        next_mem_size    = mem_size;
        next_result_data = result_data;
        next_pend_dst    = pend_dst;
        next_pend_pull   = pend_pull;
        unique case (state)
            ctad_pkg::ST_IDLE: begin
                if (op_valid && bad) begin
                    next_op_illegal = 1'b1;
                    next_op_done    = 1'b1;
                end else if (op_valid) begin
                    if (u_nz) begin
                        next_flag_n = a_n;
                        next_flag_z = a_z;
                    end
                    if (u_v) begin
                        next_flag_v = a_v;
                    end
                    if (u_c) begin
                        next_flag_c = a_c;
                        next_flag_h = a_h;
                    end
                    next_mem_size  = op_size;
                    next_pend_dst  = dst_sel;
                    next_mem_wdata = alu_b;
                    unique case (op_code)
                        ctad_pkg::OP_XFER_LOAD: begin
                            next_mem_addr  = gpr[src_sel[2:0]] + disp_val;
                            next_pend_pull = 1'b0;
                            next_mem_req   = 1'b1;
                            next_mem_we    = 1'b0;
                            next_state     = ctad_pkg::ST_MEM;
                        end
                        ctad_pkg::OP_XFER_STORE: begin
                            next_mem_addr = gpr[dst_sel[2:0]] + disp_val;
                            next_mem_req  = 1'b1;
                            next_mem_we   = 1'b1;
                            next_state    = ctad_pkg::ST_MEM;
                        end
                        ctad_pkg::OP_STACK_PULL: begin
                            next_mem_addr  = sp_val;
                            next_pend_pull = 1'b1;
                            next_mem_req   = 1'b1;
                            next_mem_we    = 1'b0;
                            next_state     = ctad_pkg::ST_MEM;
                        end
                        ctad_pkg::OP_STACK_STORE: begin
                            next_mem_addr = sp_val - sp_step;
                            next_gpr[`CTAD_SP_IDX] = sp_val - sp_step;
                            next_mem_req  = 1'b1;
                            next_mem_we   = 1'b1;
                            next_state    = ctad_pkg::ST_MEM;
                        end
                        default: begin
                            next_gpr[dst_sel[2:0]] =
                                view_wr(gpr[dst_sel[2:0]], alu_res, wr_size,
                                        dst_sel[3]);
                            next_result_data = alu_res;
                            next_op_done     = 1'b1;
                        end
                    endcase
                end
            end
            ctad_pkg::ST_MEM: begin
                if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_op_done = 1'b1;
                    next_state   = ctad_pkg::ST_IDLE;
                    if (!mem_we) begin
                        next_flag_n = a_n;
                        next_flag_z = a_z;
                        next_flag_v = 1'b0;
                        next_result_data = alu_res;
                        next_gpr[pend_dst[2:0]] =
                            view_wr(gpr[pend_dst[2:0]], alu_res, mem_size,
                                    pend_dst[3]);
                        if (pend_pull) begin
                            next_gpr[`CTAD_SP_IDX] = sp_val +
                                ((mem_size == ctad_pkg::SZ_LONG) ?
                                 `CTAD_STEP_4 : `CTAD_STEP_2);
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state       <= ctad_pkg::ST_IDLE;
            gpr         <= '{default: `CTAD_GPR_RST};
            {flag_n, flag_z, flag_v, flag_c, flag_h} <= {5{`CTAD_FLAG_RST}};
            {op_done, op_illegal, op_busy, mem_req, mem_we} <= 5'h00;
            {mem_addr, mem_wdata, result_data} <= 96'h0;
            mem_size    <= ctad_pkg::SZ_BYTE;
            pend_dst    <= 4'h0;
            pend_pull   <= 1'b0;
        end else begin
            state       <= next_state;
            gpr         <= next_gpr;
            {flag_n, flag_z, flag_v, flag_c, flag_h} <= {next_flag_n,
                next_flag_z, next_flag_v, next_flag_c, next_flag_h};
            op_done     <= next_op_done;
            op_illegal  <= next_op_illegal;
            op_busy     <= (next_state == ctad_pkg::ST_MEM);
            mem_req     <= next_mem_req;
            mem_we      <= next_mem_we;
            mem_addr    <= next_mem_addr;
            mem_wdata   <= next_mem_wdata;
            mem_size    <= next_mem_size;
            result_data <= next_result_data;
            pend_dst    <= next_pend_dst;
            pend_pull   <= next_pend_pull;
        end
    end

endmodule // ctad_datapath
`default_nettype wire

// *** tb/ctad_mem_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ctad_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    input  wire logic [1:0]  slow,
    output logic             mem_ack = 1'b0,
    output logic [31:0]      mem_rdata = 32'h0
);
    logic [1:0] wait_cnt = 2'h0;
    // Data toggles outside the ack cycle so stale reads show
    always @(posedge sys_clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack) begin
            if (wait_cnt == slow) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem_addr ^ 32'hA5A5_0000;
                wait_cnt <= 2'h0;
            end else wait_cnt <= wait_cnt + 2'h1;
        end
    end
endmodule // ctad_mem_model
`default_nettype wire

// *** tb/ctad_datapath_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module ctad_datapath_assertions (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 op_valid,
    input wire ctad_pkg::ctad_op_t   op_code,
    input wire ctad_pkg::ctad_size_t op_size,
    input wire logic                 src_is_imm,
    input wire logic [23:0]          field_raw,
    input wire logic                 mem_ack,
    input wire logic                 op_done,
    input wire logic                 op_illegal,
    input wire logic                 op_busy,
    input wire logic                 mem_req,
    input wire logic [31:0]          mem_addr,
    input wire logic                 flag_n,
    input wire logic                 flag_z,
    input wire logic                 flag_v,
    input wire logic                 flag_c
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic go;
    logic byt;
    assign go = op_valid && !op_busy;
    assign byt = op_size == ctad_pkg::SZ_BYTE;
    AST_ILL_DONE: assert property (op_illegal |-> op_done)
        else $error("refusal without done");
    AST_SUM_DONE: assert property (go && op_code == ctad_pkg::OP_SUM
        |=> op_done && !op_busy && !mem_req) else $error("sum late");
    AST_PSYNC: assert property (go && op_code inside {ctad_pkg::OP_PSYNC_RD,
        ctad_pkg::OP_PSYNC_WR} |=> op_illegal) else $error("psync taken");
    AST_DIFF_IMM: assert property (go && op_code == ctad_pkg::OP_DIFF
        && byt && src_is_imm |=> op_illegal) else $error("byte imm diff");
    AST_STEP_TWO: assert property (go && op_code == ctad_pkg::OP_STEP_UP
        && byt && field_raw == 24'h2 |=> op_illegal) else $error("byte step 2");
    AST_STACK_BYTE: assert property (go && byt && op_code inside
        {ctad_pkg::OP_STACK_PULL, ctad_pkg::OP_STACK_STORE} |=> op_illegal)
        else $error("byte stack op");
    AST_PTR_FLAGS: assert property (go && op_code == ctad_pkg::OP_PTR_DOWN
        |=> $stable({flag_n, flag_z, flag_v, flag_c})) else $error("ptr flags");
    AST_LOAD_REQ: assert property (go && op_code == ctad_pkg::OP_XFER_LOAD
        |=> mem_req && op_busy && !op_done) else $error("no load request");
    AST_HOLD: assert property (mem_req && !mem_ack |=> mem_req &&
        $stable(mem_addr)) else $error("request dropped");
    AST_ACK_DONE: assert property (mem_req && mem_ack |=> op_done &&
        !mem_req && !op_busy) else $error("ack not finished");
endmodule // ctad_datapath_assertions
`default_nettype wire

// *** tb/tb_cpu_transfer_arith_datapath.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_transfer_arith_datapath;
    logic sys_clk = 1'b0, rst_n = 1'b0, op_valid = 1'b0, src_is_imm = 1'b0;
    logic op_done, op_illegal, op_busy, mem_req, mem_we, mem_ack, ill, mwe;
    logic flag_n, flag_z, flag_v, flag_c;
    logic [1:0] field_len = 2'h0, slow = 2'h1;
    logic [3:0] dst_sel = 4'h0, src_sel = 4'h0;
    logic [23:0] field_raw = 24'h0;
    logic [31:0] mem_rdata, mem_addr, mem_wdata, result_data, ma, mwd;
    ctad_pkg::ctad_op_t op_code = ctad_pkg::OP_XFER_RR;
    ctad_pkg::ctad_size_t op_size = ctad_pkg::SZ_BYTE, mem_size;
    int n_mismatch = 0, samples_checked = 0, cyc = 0;
    ctad_datapath i_ctad_datapath (.sys_clk, .rst_n, .op_valid, .op_code,
        .op_size, .dst_sel, .src_sel, .src_is_imm, .field_raw, .field_len,
        .mem_rdata, .mem_ack, .op_done, .op_illegal, .op_busy, .mem_req,
        .mem_we, .mem_addr, .mem_wdata, .mem_size, .result_data, .flag_n,
        .flag_z, .flag_v, .flag_c);
    ctad_mem_model i_ctad_mem_model (.sys_clk, .mem_req, .mem_addr, .slow,
        .mem_ack, .mem_rdata);
    always #12.5 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic op(input logic [4:0] c, input logic [1:0] s,
        input logic [3:0] d, input logic [3:0] r, input logic im,
        input logic [23:0] f, input logic [1:0] l);
        @(posedge sys_clk);
        op_valid <= 1'b1;
        op_code <= ctad_pkg::ctad_op_t'(c);
        op_size <= ctad_pkg::ctad_size_t'(s);
        dst_sel <= d;
        src_sel <= r;
        src_is_imm <= im;
        field_raw <= f;
        field_len <= l;
        @(posedge sys_clk);
        op_valid <= 1'b0;
        #1;
        for (int k = 0; k < 20 && op_done !== 1'b1; k++) begin
            if (mem_req === 1'b1) {ma, mwd, mwe} = {mem_addr, mem_wdata, mem_we};
            @(posedge sys_clk);
            #1;
        end
        ill = op_illegal;
        chk(op_done, 1'b1);
    endtask
    task automatic rd(input logic [2:0] r, input logic [31:0] e);
        op(5'h00, 2'h2, 4'h6, {1'b0, r}, 1'b0, 24'h0, 2'h0);
        chk(result_data, e);
    endtask
    task automatic t_arith;
        op(5'h01, 2'h2, 4'h0, 4'h0, 1'b1, 24'hABCDEF, 2'h3);
        chk(result_data, 32'h00ABCDEF);
        op(5'h01, 2'h0, 4'h0, 4'h0, 1'b1, 24'h12, 2'h1);
        rd(3'h0, 32'h00AB12EF);
        op(5'h06, 2'h0, 4'h8, 4'h0, 1'b1, 24'h11, 2'h1);
        chk({flag_n, flag_z, flag_v, flag_c}, 4'h5);
        op(5'h08, 2'h0, 4'h8, 4'h0, 1'b1, 24'h05, 2'h1);
        rd(3'h0, 32'h00AB1206);
        op(5'h01, 2'h0, 4'hD, 4'h0, 1'b1, 24'h09, 2'h1);
        op(5'h06, 2'h0, 4'hD, 4'h0, 1'b1, 24'h01, 2'h1);
        op(5'h0E, 2'h0, 4'hD, 4'h0, 1'b0, 24'h0, 2'h1);
        rd(3'h5, 32'h00000010);
    endtask
    task automatic t_refuse;
        logic [4:0] bad [6] = '{5'h07, 5'h0A, 5'h04, 5'h12, 5'h13, 5'h10};
        for (int i = 0; i < 6; i++) begin
            op(bad[i], (i == 5) ? 2'h2 : 2'h0, 4'h8, 4'h8, 1'b1, 24'h2, 2'h1);
            chk(ill, 1'b1);
        end
        rd(3'h0, 32'h00AB1206);
    endtask
    task automatic t_step_mul;
        op(5'h0B, 2'h1, 4'h0, 4'h0, 1'b0, 24'h2, 2'h1);
        rd(3'h0, 32'h00AB1204);
        op(5'h0D, 2'h2, 4'h0, 4'h0, 1'b0, 24'h4, 2'h1);
        rd(3'h0, 32'h00AB1200);
        op(5'h01, 2'h2, 4'h1, 4'h0, 1'b1, 24'hFF, 2'h1);
        op(5'h01, 2'h2, 4'h2, 4'h0, 1'b1, 24'hFF, 2'h1);
        op(5'h10, 2'h0, 4'h1, 4'hA, 1'b0, 24'h0, 2'h0);
        rd(3'h1, 32'h0000FE01);
        op(5'h11, 2'h0, 4'h1, 4'hA, 1'b0, 24'h0, 2'h0);
        rd(3'h1, 32'h0000FFFF);
    endtask
    task automatic t_mem;
        op(5'h01, 2'h2, 4'h7, 4'h0, 1'b1, 24'h100, 2'h2);
        op(5'h05, 2'h2, 4'h0, 4'h0, 1'b0, 24'h0, 2'h0);
        chk(mwe, 1'b1);
        chk(ma, 32'hFC);
        chk(mwd, 32'h00AB1200);
        slow <= 2'h0;
        op(5'h04, 2'h2, 4'h3, 4'h0, 1'b0, 24'h0, 2'h0);
        chk(ma, 32'hFC);
        rd(3'h3, 32'hA5A500FC);
        rd(3'h7, 32'h100);
        op(5'h02, 2'h2, 4'h4, 4'h7, 1'b0, 24'h8, 2'h1);
        rd(3'h4, 32'hA5A50108);
    endtask
    task automatic give_verdict;
        $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict;
        end
    end
    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_arith;
        t_refuse;
        t_step_mul;
        t_mem;
        give_verdict;
    end
endmodule // tb_cpu_transfer_arith_datapath
bind ctad_datapath ctad_datapath_assertions i_ctad_datapath_assertions (
    .sys_clk, .rst_n, .op_valid, .op_code, .op_size, .src_is_imm, .field_raw,
    .mem_ack, .op_done, .op_illegal, .op_busy, .mem_req, .mem_addr, .flag_n,
    .flag_z, .flag_v, .flag_c);
`default_nettype wire
